//--- design/dedc_pkg.sv
// constants and carrier types for the detection end delay control
package dedc_pkg;
  // clock and time base
  localparam int CLOCK_HZ = 40_000_000;
  localparam int TICK_S = 1;
  localparam int TICK_CYCLES = CLOCK_HZ * TICK_S;
  localparam int STD_DELAY_S = 10;
  localparam int EARLY_LIMIT_S = 10;
  localparam logic [7:0] STD_DELAY_TICKS = 8'(STD_DELAY_S / TICK_S);
  localparam logic [7:0] EARLY_LIMIT_TICKS = 8'(EARLY_LIMIT_S / TICK_S);
  // adaptive learning steps and decay period in seconds, factor of one
  localparam logic [15:0] LEARN_STEP_S = 16'h0005;
  localparam logic [15:0] EARLY_STEP_S = 16'h000a;
  localparam logic [15:0] DECAY_PERIOD_S = 16'h003c;
  localparam logic [7:0] FACTOR_ONE = 8'h01;
  // register byte offsets
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_ADD_TIME = 8'h04;
  localparam logic [7:0] OFF_MIN_ADD = 8'h08;
  localparam logic [7:0] OFF_MAX_ADD = 8'h0c;
  localparam logic [7:0] OFF_BRIEF_WIN = 8'h10;
  localparam logic [7:0] OFF_HYST = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  localparam logic [7:0] OFF_LEARNED = 8'h1c;
  localparam logic [7:0] OFF_FACTOR = 8'h20;
  // control register fields
  localparam int CTRL_ADAPT = 0;
  localparam int CTRL_FACT_EXT = 1;
  localparam int CTRL_BRIEF_EN = 2;
  localparam int CTRL_PRESENCE = 3;
  localparam int CTRL_OUT_EN = 4;
  localparam int CTRL_OUT_VAL = 6;
  // reset values
  localparam logic [7:0] CTRL_RST = 8'h30;
  localparam logic [15:0] ADD_TIME_RST = 16'h003c;
  localparam logic [15:0] MIN_ADD_RST = 16'h001e;
  localparam logic [15:0] MAX_ADD_RST = 16'h0258;
  localparam logic [7:0] BRIEF_WIN_RST = 8'h05;
  localparam logic [15:0] HYST_RST = 16'h0064;

  typedef enum logic [1:0] {PH_IDLE, PH_STD, PH_ADD} dedc_phase_t;

  typedef struct packed {
    logic adaptive;
    logic factor_ext;
    logic brief_en;
    logic presence;
    logic [1:0] out_en;
    logic [1:0] out_val;
    logic [15:0] add_time;
    logic [15:0] min_add;
    logic [15:0] max_add;
    logic [7:0] brief_win;
    logic [15:0] hyst;
  } dedc_cfg_t;

  typedef struct packed {
    dedc_phase_t phase;
    logic excess;
    logic brief_armed;
    logic brief_block;
    logic [15:0] learned;
    logic [7:0] factor;
  } dedc_status_t;

  typedef struct packed {
    dedc_phase_t phase;
    logic [7:0] std_cnt;
    logic [23:0] add_cnt;
    logic [7:0] factor;
    logic [15:0] learned;
    logic [15:0] decay_cnt;
    logic [7:0] off_cnt;
    logic off_valid;
    logic [7:0] win_cnt;
    logic win_done;
    logic brief_armed;
    logic brief_block;
    logic motion_q;
    logic [1:0] send;
    logic [1:0] val;
  } dedc_core_t;
endpackage

//--- design/dedc_tick.sv
// one-cycle seconds tick from the system clock
`timescale 1ns/10ps
module dedc_tick #(
  parameter int TICK_CYCLES = dedc_pkg::TICK_CYCLES
) (
  input wire logic clock_i,
  input wire logic reset_n_i,
  output logic tick_o
);
  if (TICK_CYCLES < 1) begin : g_chk
    $error("tick period must be at least one cycle");
  end

  logic [31:0] cnt;
  logic [31:0] next_cnt;

  always_comb begin
    next_cnt = cnt + 32'h0000_0001;
    if (cnt >= 32'(TICK_CYCLES - 1)) begin
      next_cnt = 32'h0000_0000;
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      cnt <= 32'h0000_0000;
    end else begin
      cnt <= next_cnt;
    end
  end

  assign tick_o = (cnt >= 32'(TICK_CYCLES - 1));
endmodule

//--- design/dedc_regs.sv
// ahb-lite slave holding configuration and showing status
`timescale 1ns/10ps
module dedc_regs (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  input wire dedc_pkg::dedc_status_t status_i,
  output dedc_pkg::dedc_cfg_t cfg_o
);
  typedef struct packed {
    dedc_pkg::dedc_cfg_t cfg;
    logic wr_pend;
    logic [7:0] wr_addr;
    logic [31:0] rdata;
  } dedc_regs_st_t;

  dedc_regs_st_t s;
  dedc_regs_st_t next_s;
  logic take;

  always_comb begin
    next_s = s;
    take = hsel_i && htrans_i[1] && hready_i && (hsize_i == 3'b010);
    next_s.wr_pend = take && hwrite_i;
    if (take) begin
      next_s.wr_addr = haddr_i[7:0];
    end
    if (s.wr_pend) begin
      unique case (s.wr_addr)
        dedc_pkg::OFF_CTRL: begin
          next_s.cfg.adaptive = hwdata_i[dedc_pkg::CTRL_ADAPT];
          next_s.cfg.factor_ext = hwdata_i[dedc_pkg::CTRL_FACT_EXT];
          next_s.cfg.brief_en = hwdata_i[dedc_pkg::CTRL_BRIEF_EN];
          next_s.cfg.presence = hwdata_i[dedc_pkg::CTRL_PRESENCE];
          next_s.cfg.out_en = hwdata_i[dedc_pkg::CTRL_OUT_EN +: 2];
          next_s.cfg.out_val = hwdata_i[dedc_pkg::CTRL_OUT_VAL +: 2];
        end
        dedc_pkg::OFF_ADD_TIME: next_s.cfg.add_time = hwdata_i[15:0];
        dedc_pkg::OFF_MIN_ADD: next_s.cfg.min_add = hwdata_i[15:0];
        dedc_pkg::OFF_MAX_ADD: next_s.cfg.max_add = hwdata_i[15:0];
        dedc_pkg::OFF_BRIEF_WIN: next_s.cfg.brief_win = hwdata_i[7:0];
        dedc_pkg::OFF_HYST: next_s.cfg.hyst = hwdata_i[15:0];
        default: begin
        end
      endcase
    end
    next_s.rdata = 32'h0000_0000;
    if (take && !hwrite_i) begin
      unique case (haddr_i[7:0])
        dedc_pkg::OFF_CTRL: next_s.rdata = {24'h00_0000, s.cfg.out_val, s.cfg.out_en,
          s.cfg.presence, s.cfg.brief_en, s.cfg.factor_ext, s.cfg.adaptive};
        dedc_pkg::OFF_ADD_TIME: next_s.rdata = {16'h0000, s.cfg.add_time};
        dedc_pkg::OFF_MIN_ADD: next_s.rdata = {16'h0000, s.cfg.min_add};
        dedc_pkg::OFF_MAX_ADD: next_s.rdata = {16'h0000, s.cfg.max_add};
        dedc_pkg::OFF_BRIEF_WIN: next_s.rdata = {24'h00_0000, s.cfg.brief_win};
        dedc_pkg::OFF_HYST: next_s.rdata = {16'h0000, s.cfg.hyst};
        dedc_pkg::OFF_STATUS: next_s.rdata = {27'h000_0000, status_i.brief_block,
          status_i.brief_armed, status_i.excess, status_i.phase};
        dedc_pkg::OFF_LEARNED: next_s.rdata = {16'h0000, status_i.learned};
        dedc_pkg::OFF_FACTOR: next_s.rdata = {24'h00_0000, status_i.factor};
        default: next_s.rdata = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      s.cfg.adaptive <= dedc_pkg::CTRL_RST[dedc_pkg::CTRL_ADAPT];
      s.cfg.factor_ext <= dedc_pkg::CTRL_RST[dedc_pkg::CTRL_FACT_EXT];
      s.cfg.brief_en <= dedc_pkg::CTRL_RST[dedc_pkg::CTRL_BRIEF_EN];
      s.cfg.presence <= dedc_pkg::CTRL_RST[dedc_pkg::CTRL_PRESENCE];
      s.cfg.out_en <= dedc_pkg::CTRL_RST[dedc_pkg::CTRL_OUT_EN +: 2];
      s.cfg.out_val <= dedc_pkg::CTRL_RST[dedc_pkg::CTRL_OUT_VAL +: 2];
      s.cfg.add_time <= dedc_pkg::ADD_TIME_RST;
      s.cfg.min_add <= dedc_pkg::MIN_ADD_RST;
      s.cfg.max_add <= dedc_pkg::MAX_ADD_RST;
      s.cfg.brief_win <= dedc_pkg::BRIEF_WIN_RST;
      s.cfg.hyst <= dedc_pkg::HYST_RST;
      s.wr_pend <= 1'b0;
      s.wr_addr <= 8'h00;
      s.rdata <= 32'h0000_0000;
    end else begin
      s <= next_s;
    end
  end

  assign cfg_o = s.cfg;
  assign hrdata_o = s.rdata;
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
endmodule

//--- design/dedc_top.sv
// detection end delay control: standard, fixed or adaptive additional delay
//
// Behaviour
// - detection ends when motion absent and standard plus additional delay elapse
// - each of two outputs optionally sends its telegram at detection end
// - standard delay fixed 10 s, additional delay appended after it
// - control bit selects fixed or adaptive additional delay
// - fixed mode with factor: additional delay equals factor times configured time
// - new factor used only when the next additional delay starts
// - factor received while block inactive is kept for later
// - factor is 1 after reset or configuration load until received
// - adaptive delay learned from motion frequency within min and max
// - learned value rises only during evaluation, falls only while idle
// - adaptive total delay kept between 10 s plus min and max
// - restart within 10 s of detection end lengthens delay at once
// - brief-presence window starts at first motion of new detection
// - motion after window cancels brief presence, learned delay used
// - no motion after window: only minimum additional delay runs
// - brief presence leaves learned value alone, overrides it once
// - after early switch-off the next motion skips brief-presence shortening
// - motion during additional delay retriggers, restarting standard delay
// - switch-off brightness is twilight level plus hysteresis
//
// Design decisions made here: the register addresses and the AHB-Lite register port.
`timescale 1ns/10ps
module dedc_top #(
  parameter int TICK_CYCLES = dedc_pkg::TICK_CYCLES
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic HSEL_I,
  input wire logic [31:0] HADDR_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [2:0] HSIZE_I,
  input wire logic [31:0] HWDATA_I,
  input wire logic HREADY_I,
  output logic [31:0] HRDATA_O,
  output logic HREADYOUT_O,
  output logic HRESP_O,
  input wire logic MOTION_I,
  input wire logic FB_ACTIVE_I,
  input wire logic [7:0] FACTOR_I,
  input wire logic FACTOR_VALID_I,
  input wire logic CONFIG_LOAD_I,
  input wire logic [15:0] BRIGHTNESS_I,
  input wire logic [15:0] TWILIGHT_I,
  output logic [1:0] END_SEND_O,
  output logic [1:0] END_VALUE_O,
  output logic DETECTING_O
);
  dedc_pkg::dedc_cfg_t cfg;
  dedc_pkg::dedc_status_t status;
  dedc_pkg::dedc_core_t s;
  dedc_pkg::dedc_core_t next_s;
  logic tick;
  logic [16:0] off_bright;
  logic excess;
  logic rise;
  logic motion_eval;
  logic [23:0] eff_add;
  logic early_now;
  logic do_end;
  logic [16:0] learn_up;

  dedc_tick #(
    .TICK_CYCLES(TICK_CYCLES)
  ) u_tick (
    .clock_i(CLOCK_I),
    .reset_n_i(RESET_N_I),
    .tick_o(tick)
  );

  dedc_regs u_regs (
    .clock_i(CLOCK_I),
    .reset_n_i(RESET_N_I),
    .hsel_i(HSEL_I),
    .haddr_i(HADDR_I),
    .htrans_i(HTRANS_I),
    .hwrite_i(HWRITE_I),
    .hsize_i(HSIZE_I),
    .hwdata_i(HWDATA_I),
    .hready_i(HREADY_I),
    .hrdata_o(HRDATA_O),
    .hreadyout_o(HREADYOUT_O),
    .hresp_o(HRESP_O),
    .status_i(status),
    .cfg_o(cfg)
  );

  assign off_bright = {1'b0, TWILIGHT_I} + {1'b0, cfg.hyst};
  assign excess = cfg.presence && ({1'b0, BRIGHTNESS_I} > off_bright);

  always_comb begin
    next_s = s;
    next_s.send = 2'b00;
    next_s.motion_q = MOTION_I;
    rise = MOTION_I && !s.motion_q;
    motion_eval = MOTION_I && !excess;
    early_now = 1'b0;
    do_end = 1'b0;
    learn_up = 17'h0_0000;
    if (cfg.adaptive) begin
      eff_add = s.brief_armed ? {8'h00, cfg.min_add} : {8'h00, s.learned};
    end else if (cfg.factor_ext) begin
      eff_add = 24'(s.factor) * 24'(cfg.add_time);
    end else begin
      eff_add = {8'h00, cfg.add_time};
    end

    // factor back to one on configuration load
    if (CONFIG_LOAD_I) begin
      next_s.factor = dedc_pkg::FACTOR_ONE;
    end else if (FACTOR_VALID_I) begin
      next_s.factor = FACTOR_I;
    end

    if (tick && s.win_cnt != 8'h00) begin
      next_s.win_cnt = s.win_cnt - 8'h01;
      next_s.win_done = (s.win_cnt == 8'h01);
    end
    // motion after window drops brief presence
    if (s.win_done && rise && !excess && s.phase != dedc_pkg::PH_IDLE) begin
      next_s.brief_armed = 1'b0;
    end

    if (!FB_ACTIVE_I) begin
      next_s.phase = dedc_pkg::PH_IDLE;
      next_s.std_cnt = 8'h00;
      next_s.add_cnt = 24'h00_0000;
      next_s.win_cnt = 8'h00;
      next_s.brief_armed = 1'b0;
    end else begin
      unique case (s.phase)
        dedc_pkg::PH_IDLE: begin
          if (tick) begin
            if (s.off_cnt != 8'hff) begin
              next_s.off_cnt = s.off_cnt + 8'h01;
            end
            if (cfg.adaptive && s.decay_cnt >= dedc_pkg::DECAY_PERIOD_S - 16'h0001) begin
              next_s.decay_cnt = 16'h0000;
              next_s.learned = (s.learned > dedc_pkg::LEARN_STEP_S) ?
                s.learned - dedc_pkg::LEARN_STEP_S : 16'h0000;
            end else begin
              next_s.decay_cnt = s.decay_cnt + 16'h0001;
            end
          end
          if (motion_eval) begin
            next_s.phase = dedc_pkg::PH_STD;
            next_s.std_cnt = dedc_pkg::STD_DELAY_TICKS;
            next_s.decay_cnt = 16'h0000;
            early_now = cfg.adaptive && s.off_valid &&
              (s.off_cnt < dedc_pkg::EARLY_LIMIT_TICKS);
            if (early_now) begin
              learn_up = {1'b0, s.learned} + {1'b0, dedc_pkg::EARLY_STEP_S};
              next_s.learned = learn_up[16] ? 16'hffff : learn_up[15:0];
            end
            next_s.brief_block = early_now;
            if (cfg.adaptive && cfg.brief_en && !early_now && cfg.brief_win != 8'h00) begin
              next_s.brief_armed = 1'b1;
              next_s.win_cnt = cfg.brief_win;
              next_s.win_done = 1'b0;
            end else begin
              next_s.brief_armed = 1'b0;
              next_s.win_cnt = 8'h00;
              next_s.win_done = 1'b0;
            end
          end
        end
        dedc_pkg::PH_STD: begin
          if (motion_eval) begin
            // standard delay runs after last motion
            next_s.std_cnt = dedc_pkg::STD_DELAY_TICKS;
          end else if (tick) begin
            if (s.std_cnt <= 8'h01) begin
              // factor sampled at start of delay
              next_s.add_cnt = eff_add;
              next_s.phase = dedc_pkg::PH_ADD;
              next_s.brief_armed = 1'b0;
              if (eff_add == 24'h00_0000) begin
                do_end = 1'b1;
              end
            end else begin
              next_s.std_cnt = s.std_cnt - 8'h01;
            end
          end
        end
        dedc_pkg::PH_ADD: begin
          if (motion_eval) begin
            next_s.phase = dedc_pkg::PH_STD;
            next_s.std_cnt = dedc_pkg::STD_DELAY_TICKS;
            if (cfg.adaptive && rise) begin
              learn_up = {1'b0, s.learned} + {1'b0, dedc_pkg::LEARN_STEP_S};
              next_s.learned = learn_up[16] ? 16'hffff : learn_up[15:0];
            end
          end else if (tick) begin
            if (s.add_cnt <= 24'h00_0001) begin
              do_end = 1'b1;
            end else begin
              next_s.add_cnt = s.add_cnt - 24'h00_0001;
            end
          end
        end
        default: begin
          next_s.phase = dedc_pkg::PH_IDLE;
        end
      endcase
    end

    if (do_end) begin
      next_s.phase = dedc_pkg::PH_IDLE;
      next_s.add_cnt = 24'h00_0000;
      next_s.std_cnt = 8'h00;
      next_s.off_cnt = 8'h00;
      next_s.off_valid = 1'b1;
      next_s.decay_cnt = 16'h0000;
      next_s.brief_armed = 1'b0;
      next_s.win_cnt = 8'h00;
      next_s.send = cfg.out_en;
      next_s.val = cfg.out_val;
    end

    if (cfg.min_add <= cfg.max_add) begin
      if (next_s.learned < cfg.min_add) begin
        next_s.learned = cfg.min_add;
      end else if (next_s.learned > cfg.max_add) begin
        next_s.learned = cfg.max_add;
      end
    end
  end

  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I) begin
      s.phase <= dedc_pkg::PH_IDLE;
      s.std_cnt <= 8'h00;
      s.add_cnt <= 24'h00_0000;
      s.factor <= dedc_pkg::FACTOR_ONE;
      s.learned <= dedc_pkg::MIN_ADD_RST;
      s.decay_cnt <= 16'h0000;
      s.off_cnt <= 8'h00;
      s.off_valid <= 1'b0;
      s.win_cnt <= 8'h00;
      s.win_done <= 1'b0;
      s.brief_armed <= 1'b0;
      s.brief_block <= 1'b0;
      s.motion_q <= 1'b0;
      s.send <= 2'b00;
      s.val <= 2'b00;
    end else begin
      s <= next_s;
    end
  end

  assign status.phase = s.phase;
  assign status.excess = excess;
  assign status.brief_armed = s.brief_armed;
  assign status.brief_block = s.brief_block;
  assign status.learned = s.learned;
  assign status.factor = s.factor;

  assign END_SEND_O = s.send;
  assign END_VALUE_O = s.val;
  assign DETECTING_O = (s.phase != dedc_pkg::PH_IDLE);
endmodule

//--- verification/dedc_assertions.sv
// port assertions for the detection end delay control
`timescale 1ns/10ps
module dedc_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic CLOCK_I,
  input wire logic RESET_N_I,
  input wire logic HSEL_I,
  input wire logic [1:0] HTRANS_I,
  input wire logic HWRITE_I,
  input wire logic [31:0] HRDATA_O,
  input wire logic HREADYOUT_O,
  input wire logic HRESP_O,
  input wire logic MOTION_I,
  input wire logic FB_ACTIVE_I,
  input wire logic [15:0] BRIGHTNESS_I,
  input wire logic [15:0] TWILIGHT_I,
  input wire logic [1:0] END_SEND_O,
  input wire logic [1:0] END_VALUE_O,
  input wire logic DETECTING_O
);
  int quiet;
  logic calm;
  assign calm = BRIGHTNESS_I <= TWILIGHT_I;
  // cycles since motion last seen
  always_ff @(posedge CLOCK_I) begin
    if (!RESET_N_I || MOTION_I) begin
      quiet <= 0;
    end else if (quiet < 1000000) begin
      quiet <= quiet + 1;
    end
  end
  default clocking @(posedge CLOCK_I);
  endclocking
  default disable iff (!RESET_N_I);
  a_bus_okay: assert property (HRESP_O == 1'b0 && HREADYOUT_O == 1'b1)
    else $error("bus answer not okay");
  a_read_idle: assert property (!(HSEL_I && HTRANS_I[1] && !HWRITE_I) |=> HRDATA_O == 32'h0)
    else $error("read data outside a read");
  a_send_pulse: assert property (END_SEND_O != 2'b00 |=> END_SEND_O == 2'b00)
    else $error("telegram pulse too long");
  a_send_ends: assert property (END_SEND_O != 2'b00 |-> $past(DETECTING_O) && !DETECTING_O)
    else $error("telegram without detection end");
  a_value_hold: assert property (!$past(DETECTING_O) |-> $stable(END_VALUE_O))
    else $error("telegram value changed without end");
  a_motion_start: assert property (MOTION_I && FB_ACTIVE_I && calm |=> DETECTING_O)
    else $error("motion did not start detection");
  a_no_end_moving: assert property (MOTION_I && FB_ACTIVE_I && calm ##1 MOTION_I
    |=> END_SEND_O == 2'b00)
    else $error("detection ended during motion");
  a_std_floor: assert property (END_SEND_O != 2'b00 |-> quiet >= 9 * TICK_CYCLES)
    else $error("detection ended before standard delay");
  a_inactive_idle: assert property ((!FB_ACTIVE_I) [*2] |-> !DETECTING_O && END_SEND_O == 2'b00)
    else $error("inactive block still detecting");
  c_both: cover property (END_SEND_O == 2'b11);
  c_one: cover property (END_SEND_O == 2'b10);
  c_retrig: cover property (DETECTING_O && $rose(MOTION_I));
  c_abort: cover property ($fell(FB_ACTIVE_I) && DETECTING_O);
endmodule

bind dedc_top dedc_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .CLOCK_I(CLOCK_I), .RESET_N_I(RESET_N_I), .HSEL_I(HSEL_I), .HTRANS_I(HTRANS_I),
  .HWRITE_I(HWRITE_I), .HRDATA_O(HRDATA_O), .HREADYOUT_O(HREADYOUT_O), .HRESP_O(HRESP_O),
  .MOTION_I(MOTION_I), .FB_ACTIVE_I(FB_ACTIVE_I), .BRIGHTNESS_I(BRIGHTNESS_I),
  .TWILIGHT_I(TWILIGHT_I), .END_SEND_O(END_SEND_O), .END_VALUE_O(END_VALUE_O),
  .DETECTING_O(DETECTING_O)
);

//--- verification/dedc_sensor.sv
// motion sensor and telegram receiver model
`timescale 1ns/10ps
module dedc_sensor (
  input wire logic clock_i,
  input wire logic reset_n_i,
  input wire logic go_i,
  input wire logic [7:0] len_i,
  input wire logic [1:0] send_i,
  output logic motion_o,
  output logic [7:0] sends_o
);
  logic [7:0] left;
  // motion burst of set length, idle low
  always_ff @(posedge clock_i) begin
    if (!reset_n_i) begin
      left <= 8'h00;
      sends_o <= 8'h00;
    end else begin
      if (go_i) begin
        left <= len_i;
      end else if (left != 8'h00) begin
        left <= left - 8'h01;
      end
      if (send_i != 2'b00) begin
        sends_o <= sends_o + 8'h01;
      end
    end
  end
  assign motion_o = left != 8'h00;
endmodule

//--- verification/detection_end_delay_control_bench.sv
// self-checking bench for the detection end delay control
`timescale 1ns/10ps
module detection_end_delay_control_bench;
  localparam int TK = 4;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'b00;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [31:0] hrdata;
  logic hready;
  logic hresp;
  logic motion;
  logic fb_on = 1'b1;
  logic [7:0] fac = 8'h00;
  logic fac_v = 1'b0;
  logic cfg_ld = 1'b0;
  logic [15:0] bright = 16'h0;
  logic boost = 1'b0;
  logic [1:0] send;
  logic [1:0] val;
  logic detect;
  logic go = 1'b0;
  logic [7:0] len = 8'h00;
  logic [7:0] sends;
  logic [1:0] exp_en;
  logic [1:0] exp_val;
  logic [31:0] rd;
  logic [7:0] ra [10] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h14, 8'h18, 8'h1c, 8'h20, 8'h40};
  logic [31:0] rv [10] = '{32'h30, 32'h3c, 32'h1e, 32'h258, 32'h5, 32'h64, 32'h0, 32'h1e,
    32'h1, 32'h0};
  int mismatches = 0;
  int n_checks = 0;
  int cyc = 0;
  int n_exp = 0;
  int f, g, h, n;
  always #12.5 clk = ~clk;
  dedc_top #(.TICK_CYCLES(TK)) u_dut (
    .CLOCK_I(clk), .RESET_N_I(rst_n), .HSEL_I(hsel), .HADDR_I(haddr), .HTRANS_I(htrans),
    .HWRITE_I(hwrite), .HSIZE_I(3'b010), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp), .MOTION_I(motion),
    .FB_ACTIVE_I(fb_on), .FACTOR_I(fac), .FACTOR_VALID_I(fac_v), .CONFIG_LOAD_I(cfg_ld),
    .BRIGHTNESS_I(bright), .TWILIGHT_I(16'h0100), .END_SEND_O(send), .END_VALUE_O(val),
    .DETECTING_O(detect)
  );
  dedc_sensor u_sensor (
    .clock_i(clk), .reset_n_i(rst_n), .go_i(go), .len_i(len), .send_i(send),
    .motion_o(motion), .sends_o(sends)
  );
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task finish_test;
    if (mismatches == 0 && n_checks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task tk(input int k);
    repeat (k) @(posedge clk);
  endtask
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= 2'b10;
    hwrite <= w;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task rchk(input logic [7:0] a, input logic [31:0] e);
    bus(1'b0, a, 32'h0);
    chk(rd, e);
  endtask
  task fpulse(input int v);
    fac <= 8'(v);
    fac_v <= 1'b1;
    @(posedge clk);
    fac_v <= 1'b0;
  endtask
  task burst(input int b);
    len <= 8'(b);
    go <= 1'b1;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
  endtask
  task det(input int b, input int gap, input int mid, input int mv, input int lo, input int hi);
    int c;
    int ok;
    c = 0;
    burst(b);
    if (gap > 0) begin
      tk(gap);
      burst(b);
    end
    while (motion === 1'b1) @(posedge clk);
    while (send === 2'b00 && c < 200 * TK) begin
      @(posedge clk);
      c++;
      if (c == mid) fpulse(mv);
    end
    ok = c >= (9 + lo) * TK && c <= (10 + hi) * TK + 3;
    n_exp++;
    chk(32'(ok), 32'h1);
    chk({30'h0, send}, {30'h0, exp_en});
    chk({30'h0, val}, {30'h0, exp_val});
  endtask
  always @(posedge clk) begin
    cyc++;
    bright <= 16'($urandom % 256) + (boost ? 16'h0200 : 16'h0000);
    if (cyc > 20000) begin
      mismatches++;
      finish_test;
    end
  end
  initial begin
    n = $urandom(77736);
    f = 2 + $urandom % 2;
    g = 5 - f;
    h = 1 + $urandom % 3;
    tk(3);
    rst_n <= 1'b1;
    tk(1);
    for (int i = 0; i < 10; i++) rchk(ra[i], rv[i]);
    bus(1'b1, 8'h04, 32'h4);
    bus(1'b1, 8'h00, 32'hb0);
    exp_en = 2'b11;
    exp_val = 2'b10;
    det(3, 0, 0, 0, 4, 4);
    det(3, 3 + 11 * TK, 0, 0, 4, 4);
    bus(1'b1, 8'h00, 32'h62);
    exp_en = 2'b10;
    exp_val = 2'b01;
    fpulse(f);
    tk(1);
    det(3, 0, 11 * TK, g, 4 * f, 4 * f);
    det(3, 0, 0, 0, 4 * g, 4 * g);
    burst(3);
    fb_on <= 1'b0;
    fpulse(h);
    tk(3);
    fb_on <= 1'b1;
    tk(15 * TK);
    chk({31'h0, detect}, 32'h0);
    rchk(8'h20, 32'(h));
    det(3, 0, 0, 0, 4 * h, 4 * h);
    cfg_ld <= 1'b1;
    @(posedge clk);
    cfg_ld <= 1'b0;
    rchk(8'h20, 32'h1);
    det(3, 0, 0, 0, 4, 4);
    bus(1'b1, 8'h08, 32'h3);
    bus(1'b1, 8'h0c, 32'h6);
    bus(1'b1, 8'h10, 32'h1);
    bus(1'b1, 8'h00, 32'h35);
    exp_en = 2'b11;
    exp_val = 2'b00;
    det(3, 0, 0, 0, 3, 6);
    det(2, 0, 0, 0, 6, 6);
    rchk(8'h1c, 32'h6);
    tk(12 * TK);
    det(2, 0, 0, 0, 3, 3);
    tk(65 * TK);
    rchk(8'h1c, 32'h3);
    boost <= 1'b1;
    bus(1'b1, 8'h00, 32'h08);
    rchk(8'h18, 32'h4);
    burst(3);
    tk(2);
    chk({31'h0, detect}, 32'h0);
    chk(32'(sends), 32'(n_exp));
    finish_test;
  end
endmodule
